// ==== include/pas_pkg.sv ====
// Constants, field layouts and carriers for the error severity and correctable error registers
package pas_pkg;

    // ------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------
    localparam int          PAS_ADDR_W        = 12;            // Config space byte address
    localparam int          PAS_DATA_W        = 32;            // Register word width
    localparam int          PAS_STRB_W        = 4;             // Byte lanes per word

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] PAS_OFS_UNC_SEV   = 12'h10C;       // uncorrectable_error_severity
    localparam logic [11:0] PAS_OFS_COR_STAT  = 12'h110;       // correctable_error_status
    localparam logic [11:0] PAS_OFS_COR_MASK  = 12'h114;       // correctable_error_mask
    localparam logic [11:0] PAS_OFS_IRQ_MASK  = 12'h130;       // Interrupt mask of status layout

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          PAS_BIT_SURPRISE  = 5;             // Surprise down severity
    localparam int          PAS_BIT_RX_ERR    = 0;             // Receiver error
    localparam int          PAS_BIT_BAD_TLP   = 6;             // Bad TLP
    localparam int          PAS_BIT_BAD_DLLP  = 7;             // Bad DLLP
    localparam int          PAS_BIT_ROLLOVER  = 8;             // Replay count rollover
    localparam int          PAS_BIT_RPL_TMO   = 12;            // Replay timer timeout
    localparam int          PAS_BIT_ADV_NF    = 13;            // Advisory non-fatal

    // ------------------------------------------------------------
    // Implemented bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PAS_SEV_WMASK     = 32'h003F_F031; // Bits 0,4,5,12..21
    localparam logic [31:0] PAS_SEV_RST       = 32'h0006_2031; // Fatal: 0,4,5,13,17,18
    localparam logic [31:0] PAS_COR_WMASK     = 32'h0000_31C1; // Bits 0,6,7,8,12,13
    localparam logic [31:0] PAS_COR_STAT_RST  = 32'h0000_0000; // No event recorded
    localparam logic [31:0] PAS_COR_MASK_RST  = 32'h0000_2000; // Advisory masked
    localparam logic [31:0] PAS_IRQ_MASK_RST  = 32'h0000_31C1; // All interrupts masked

    // ------------------------------------------------------------
    // Bus response codes
    // ------------------------------------------------------------
    localparam logic [1:0]  PAS_RESP_OKAY     = 2'h0;          // Normal access
    localparam logic [1:0]  PAS_RESP_SLVERR   = 2'h2;          // Unmapped address

    // Correctable error events from link and data-link layers
    typedef struct packed {
        logic advisory_nf;     // Advisory non-fatal error
        logic replay_timeout;  // Replay timer expired
        logic replay_rollover; // Replay count rolled over
        logic bad_dllp;        // Bad DLLP received
        logic bad_tlp;         // Bad TLP received
        logic rx_err;          // Receiver error
    } pas_cor_evt_s;

    // Requests toward log and message logic
    typedef struct packed {
        logic log_req;         // Record header in log
        logic cor;             // Correctable message
        logic nonfatal;        // Non-fatal message
        logic fatal;           // Fatal message
    } pas_msg_s;

    // Whole state of the block
    typedef struct packed {
        logic        aw_rdy;   // Write address ready
        logic        w_rdy;    // Write data ready
        logic        aw_got;   // Write address held
        logic        w_got;    // Write data held
        logic [11:0] awaddr;   // Held write address
        logic [31:0] wdata;    // Held write data
        logic [3:0]  wstrb;    // Held byte strobes
        logic        bvalid;   // Write response pending
        logic [1:0]  bresp;    // Write response code
        logic        ar_rdy;   // Read address ready
        logic        rvalid;   // Read data pending
        logic [31:0] rdata;    // Read data
        logic [1:0]  rresp;    // Read response code
        logic [31:0] sev;      // Severity register
        logic [31:0] cstat;    // Correctable status
        logic [31:0] cmask;    // Correctable mask
        logic [31:0] imask;    // Interrupt mask
        logic        irq;      // Interrupt level
        pas_msg_s    msg;      // Message pulses
    } pas_state_s;

endpackage : pas_pkg

// ==== design/pas_regs.sv ====
// Error severity, correctable status and mask registers behind an AXI4-Lite slave
//
// Overview of operation
// - Severity bit zero nonfatal, one fatal; bit4 resets fatal
// - Surprise down severity used on downstream ports only
// - Receiver error sets sticky status bit 0
// - Bad TLP sets sticky status bit 6
// - Bad DLLP sets sticky status bit 7
// - Replay count rollover sets sticky status bit 8
// - Replay timer timeout sets sticky status bit 12
// - Advisory non-fatal sets sticky status bit 13
// - Mask bit 0 blocks receiver error log, message
// - Mask bit 6 blocks bad TLP log, message
// - Mask bit 7 blocks bad DLLP log, message
// - Mask bit 8 blocks rollover log, message
// - Mask bit 12 blocks timeout log, message
// - Mask bit 13 resets to one
//
// The AXI4-Lite register port was decided locally.
module pas_regs
    import pas_pkg::*;
(
    input  wire logic        mclk_in,            // Core clock, 20 MHz
    input  wire logic        rst_in,             // Normal reset, keeps sticky fields
    input  wire logic        por_rst_in,         // Power-on reset, loads every field with its reset value
    input  wire logic        downstream_port_in, // High on a downstream-facing port
    input  wire pas_cor_evt_s cor_evt_in,        // Correctable event pulses
    input  wire logic [31:0] unc_evt_in,         // Uncorrectable pulses, already unmasked
    input  wire logic [11:0] s_axil_awaddr_in,   // Write address
    input  wire logic        s_axil_awvalid_in,  // Write address valid
    output logic             s_axil_awready_out, // Write address ready
    input  wire logic [31:0] s_axil_wdata_in,    // Write data
    input  wire logic [3:0]  s_axil_wstrb_in,    // Write byte strobes
    input  wire logic        s_axil_wvalid_in,   // Write data valid
    output logic             s_axil_wready_out,  // Write data ready
    output logic [1:0]       s_axil_bresp_out,   // Write response
    output logic             s_axil_bvalid_out,  // Write response valid
    input  wire logic        s_axil_bready_in,   // Write response ready
    input  wire logic [11:0] s_axil_araddr_in,   // Read address
    input  wire logic        s_axil_arvalid_in,  // Read address valid
    output logic             s_axil_arready_out, // Read address ready
    output logic [31:0]      s_axil_rdata_out,   // Read data
    output logic [1:0]       s_axil_rresp_out,   // Read response
    output logic             s_axil_rvalid_out,  // Read data valid
    input  wire logic        s_axil_rready_in,   // Read data ready
    output pas_msg_s         msg_out,            // Log and message request pulses
    output logic             irq_out             // Level interrupt
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pas_state_s   s_r;          // Registered state
    pas_state_s   s_nxt;        // Next state
    logic [31:0]  cor_vec;      // Events placed at status positions
    logic [31:0]  cor_live;     // Events passing the mask
    logic [31:0]  sev_use;      // Severity bits usable on this port
    logic [31:0]  unc_live;     // Uncorrectable events usable on this port
    logic [31:0]  w1c;          // Status bits cleared by software

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Merge write data into old value under strobes and writable mask
    function automatic logic [31:0] pas_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb,
        input logic [31:0] wmask
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < PAS_STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res & wmask;
    endfunction : pas_merge

    // Byte-lane mask from strobes
    function automatic logic [31:0] pas_lanes(
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = 32'h0000_0000;
        for (int i = 0; i < PAS_STRB_W; i++) begin
            res[i*8 +: 8] = {8{strb[i]}};
        end
        return res;
    endfunction : pas_lanes

    // True when the address names a register of this block
    function automatic logic pas_hit(
        input logic [11:0] addr
    );
        logic res;
        res = (addr == PAS_OFS_UNC_SEV)  || (addr == PAS_OFS_COR_STAT) ||
              (addr == PAS_OFS_COR_MASK) || (addr == PAS_OFS_IRQ_MASK);
        return res;
    endfunction : pas_hit

    // ------------------------------------------------------------
    // Event classification
    // ------------------------------------------------------------

    // Place correctable events at their status positions
    always_comb begin
        cor_vec                   = 32'h0000_0000;
        cor_vec[PAS_BIT_RX_ERR]   = cor_evt_in.rx_err;
        cor_vec[PAS_BIT_BAD_TLP]  = cor_evt_in.bad_tlp;
        cor_vec[PAS_BIT_BAD_DLLP] = cor_evt_in.bad_dllp;
        cor_vec[PAS_BIT_ROLLOVER] = cor_evt_in.replay_rollover;
        cor_vec[PAS_BIT_RPL_TMO]  = cor_evt_in.replay_timeout;
        cor_vec[PAS_BIT_ADV_NF]   = cor_evt_in.advisory_nf;
    end

    // Mask gating of log and message requests
    assign cor_live = cor_vec & ~s_r.cmask;

    // Surprise down class is meaningless on an upstream port
    always_comb begin
        sev_use                   = PAS_SEV_WMASK;
        sev_use[PAS_BIT_SURPRISE] = downstream_port_in;
    end

    // Upstream ports drop surprise down events rather than misclassify them
    assign unc_live = unc_evt_in & sev_use;

    // Software clears, only on a status write that completes now
    always_comb begin
        w1c = 32'h0000_0000;
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid &&
            s_r.awaddr == PAS_OFS_COR_STAT) begin
            w1c = s_r.wdata & pas_lanes(s_r.wstrb) & PAS_COR_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Message pulses last one cycle
        s_nxt.msg.log_req  = |cor_live;
        s_nxt.msg.cor      = |cor_live;
        s_nxt.msg.fatal    = |(unc_live & s_r.sev);
        s_nxt.msg.nonfatal = |(unc_live & ~s_r.sev);

        // Finished write response
        if (s_r.bvalid && s_axil_bready_in) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.aw_rdy = 1'b1;
            s_nxt.w_rdy  = 1'b1;
        end

        // Write address accepted
        if (s_axil_awvalid_in && s_r.aw_rdy) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_rdy = 1'b0;
            s_nxt.awaddr = s_axil_awaddr_in;
        end

        // Write data accepted
        if (s_axil_wvalid_in && s_r.w_rdy) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_rdy = 1'b0;
            s_nxt.wdata = s_axil_wdata_in;
            s_nxt.wstrb = s_axil_wstrb_in;
        end

        // Both halves held: perform the write and answer
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = pas_hit(s_r.awaddr) ? PAS_RESP_OKAY : PAS_RESP_SLVERR;
            case (s_r.awaddr)
                PAS_OFS_UNC_SEV: begin
                    s_nxt.sev = pas_merge(s_r.sev, s_r.wdata, s_r.wstrb,
                                          PAS_SEV_WMASK);
                end
                PAS_OFS_COR_MASK: begin
                    s_nxt.cmask = pas_merge(s_r.cmask, s_r.wdata, s_r.wstrb,
                                            PAS_COR_WMASK);
                end
                PAS_OFS_IRQ_MASK: begin
                    s_nxt.imask = pas_merge(s_r.imask, s_r.wdata, s_r.wstrb,
                                            PAS_COR_WMASK);
                end
                default: begin
                    // Status clears via w1c, others ignored
                end
            endcase
        end

        // Status: an event in the clearing cycle wins over the clear
        s_nxt.cstat = ((s_r.cstat & ~w1c) | cor_vec) & PAS_COR_WMASK;

        // Finished read
        if (s_r.rvalid && s_axil_rready_in) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.ar_rdy = 1'b1;
        end

        // Read address accepted, data answered on the next edge
        if (s_axil_arvalid_in && s_r.ar_rdy) begin
            s_nxt.ar_rdy = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = pas_hit(s_axil_araddr_in) ? PAS_RESP_OKAY : PAS_RESP_SLVERR;
            case (s_axil_araddr_in)
                PAS_OFS_UNC_SEV: begin
                    s_nxt.rdata = s_r.sev & PAS_SEV_WMASK;
                end
                PAS_OFS_COR_STAT: begin
                    s_nxt.rdata = s_r.cstat & PAS_COR_WMASK;
                end
                PAS_OFS_COR_MASK: begin
                    s_nxt.rdata = s_r.cmask & PAS_COR_WMASK;
                end
                PAS_OFS_IRQ_MASK: begin
                    s_nxt.rdata = s_r.imask & PAS_COR_WMASK;
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;              // Unmapped reads zero
                end
            endcase
        end

        // Interrupt follows the next status and mask
        s_nxt.irq = |(s_nxt.cstat & ~s_nxt.imask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Power-on loads all reset values; normal reset keeps the sticky fields
    always_ff @(posedge mclk_in) begin
        if (por_rst_in) begin
            s_r        <= '0;
            s_r.aw_rdy <= 1'b1;
            s_r.w_rdy  <= 1'b1;
            s_r.ar_rdy <= 1'b1;
            s_r.sev    <= PAS_SEV_RST;
            s_r.cstat  <= PAS_COR_STAT_RST;
            s_r.cmask  <= PAS_COR_MASK_RST;
            s_r.imask  <= PAS_IRQ_MASK_RST;
        end else if (rst_in) begin
            s_r.aw_rdy <= 1'b1;
            s_r.w_rdy  <= 1'b1;
            s_r.ar_rdy <= 1'b1;
            s_r.aw_got <= 1'b0;
            s_r.w_got  <= 1'b0;
            s_r.awaddr <= 12'h000;
            s_r.wdata  <= 32'h0000_0000;
            s_r.wstrb  <= 4'h0;
            s_r.bvalid <= 1'b0;
            s_r.bresp  <= PAS_RESP_OKAY;
            s_r.rvalid <= 1'b0;
            s_r.rdata  <= 32'h0000_0000;
            s_r.rresp  <= PAS_RESP_OKAY;
            s_r.msg    <= '0;
            // Sticky sev, cstat, cmask, imask and irq hold their values
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------
    assign s_axil_awready_out = s_r.aw_rdy;
    assign s_axil_wready_out  = s_r.w_rdy;
    assign s_axil_bvalid_out  = s_r.bvalid;
    assign s_axil_bresp_out   = s_r.bresp;
    assign s_axil_arready_out = s_r.ar_rdy;
    assign s_axil_rvalid_out  = s_r.rvalid;
    assign s_axil_rdata_out   = s_r.rdata;
    assign s_axil_rresp_out   = s_r.rresp;
    assign msg_out            = s_r.msg;
    assign irq_out            = s_r.irq;

endmodule : pas_regs

// ==== tb/pas_rc_model.sv ====
// Root complex stand-in that counts error messages from the port
module pas_rc_model
    import pas_pkg::*;
(
    input  wire logic        mclk_in,    // Core clock
    input  wire logic        por_rst_in, // Power-on reset
    input  wire pas_msg_s    msg_in,     // Message request pulses
    output int unsigned      n_msg_out   // Messages received
);
    // ------------------------------------------------------------
    // Message counter, one per class bit seen
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (por_rst_in) begin
            n_msg_out <= 0;
        end else begin
            n_msg_out <= n_msg_out + msg_in.cor + msg_in.nonfatal + msg_in.fatal;
        end
    end
endmodule : pas_rc_model

// ==== tb/pas_regs_chk.sv ====
// Port checker for the severity and correctable error registers
module pas_regs_chk
    import pas_pkg::*;
(
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    input  wire logic         por_rst_in,
    input  wire logic         downstream_port_in,
    input  wire pas_cor_evt_s cor_evt_in,
    input  wire logic [31:0]  unc_evt_in,
    input  wire logic [11:0]  s_axil_araddr_in,
    input  wire logic         s_axil_arvalid_in,
    input  logic              s_axil_arready_out,
    input  logic [31:0]       s_axil_rdata_out,
    input  logic [1:0]        s_axil_rresp_out,
    input  logic              s_axil_rvalid_out,
    input  logic              s_axil_bvalid_out,
    input  pas_msg_s          msg_out,
    input  logic              irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (por_rst_in);

    // ------------------------------------------------------------
    // Message causes
    // ------------------------------------------------------------
    property p_cor_cause; msg_out.cor |-> $past(|cor_evt_in); endproperty
    a_cor_cause: assert property (p_cor_cause) else $error("cor message without event");
    property p_log_cor; msg_out.log_req == msg_out.cor; endproperty
    a_log_cor: assert property (p_log_cor) else $error("log and cor request differ");
    property p_fatal_cause; msg_out.fatal |-> $past(|unc_evt_in); endproperty
    a_fatal_cause: assert property (p_fatal_cause) else $error("fatal without event");
    property p_nf_cause; msg_out.nonfatal |-> $past(|unc_evt_in); endproperty
    a_nf_cause: assert property (p_nf_cause) else $error("nonfatal without event");
    property p_sd_up;
        (unc_evt_in == 32'h0000_0020 && !downstream_port_in && !rst_in)
            |=> !msg_out.fatal && !msg_out.nonfatal;
    endproperty
    a_sd_up: assert property (p_sd_up) else $error("surprise down used upstream");

    // ------------------------------------------------------------
    // Sticky interrupt level and bus answers
    // ------------------------------------------------------------
    property p_rst_keep; rst_in && irq_out |=> irq_out; endproperty
    a_rst_keep: assert property (p_rst_keep) else $error("irq lost on normal reset");
    property p_irq_fall;
        $fell(irq_out) |-> s_axil_bvalid_out || $past(s_axil_bvalid_out);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_irq_rise;
        $rose(irq_out) |-> $past(|cor_evt_in) || s_axil_bvalid_out || $past(s_axil_bvalid_out);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_unmapped;
        s_axil_arvalid_in && s_axil_arready_out && s_axil_araddr_in == 12'h000
            |=> s_axil_rvalid_out && s_axil_rdata_out == 32'h0 && s_axil_rresp_out == PAS_RESP_SLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answer wrong");

    c_cor: cover property (msg_out.cor);
    c_fatal: cover property (msg_out.fatal);
    c_irq: cover property ($rose(irq_out));
endmodule : pas_regs_chk

// ==== tb/tb.sv ====
// Self-checking bench for the error severity and correctable error registers
module tb
    import pas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         mclk_in = 1'b0;                      // Core clock
    logic         rst_in, por_rst_in, ds_port;         // Resets, port direction
    pas_cor_evt_s cor_evt;                             // Correctable pulses
    logic [31:0]  unc_evt, wdata, rdata;               // Uncorrectable pulses, data
    logic [11:0]  awaddr, araddr;                      // Bus addresses
    logic         awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]   bresp, rresp;                        // Bus responses
    logic [3:0]   wstrb = 4'hF;                        // Write byte strobes
    pas_msg_s     msg;                                 // Message pulses
    logic [33:0]  rq[$];                               // Expected bus answers
    pas_msg_s     mq[$];                               // Expected messages
    int           n_mismatch = 0, tests_run = 0, exp_msgs = 0, i;
    int unsigned  rc_total;                            // Messages at root complex
    int           bits[6] = '{0, 6, 7, 8, 12, 13};     // Status positions

    always #25 mclk_in = ~mclk_in;

    pas_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .por_rst_in(por_rst_in),
        .downstream_port_in(ds_port), .cor_evt_in(cor_evt), .unc_evt_in(unc_evt),
        .s_axil_awaddr_in(awaddr), .s_axil_awvalid_in(awvalid), .s_axil_awready_out(awready),
        .s_axil_wdata_in(wdata), .s_axil_wstrb_in(wstrb), .s_axil_wvalid_in(wvalid),
        .s_axil_wready_out(wready), .s_axil_bresp_out(bresp), .s_axil_bvalid_out(bvalid),
        .s_axil_bready_in(bready), .s_axil_araddr_in(araddr), .s_axil_arvalid_in(arvalid),
        .s_axil_arready_out(arready), .s_axil_rdata_out(rdata), .s_axil_rresp_out(rresp),
        .s_axil_rvalid_out(rvalid), .s_axil_rready_in(rready), .msg_out(msg), .irq_out(irq));
    pas_rc_model u_rc (.mclk_in(mclk_in), .por_rst_in(por_rst_in), .msg_in(msg),
        .n_msg_out(rc_total));

    // ------------------------------------------------------------
    // Compare, verdict and hang cut-off
    // ------------------------------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Bus master tasks, expectation noted before the request
    // ------------------------------------------------------------
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge mclk_in);
        rq.push_back({32'h0, r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge mclk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 64) begin n_mismatch++; tally_and_finish(); end
    endtask : axw

    task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        @(posedge mclk_in);
        rq.push_back({e, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge mclk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 64) begin n_mismatch++; tally_and_finish(); end
    endtask : axr

    // One-cycle event pulse, message expected at the next edge
    task automatic ev(input pas_cor_evt_s c, input logic [31:0] u, input pas_msg_s m);
        @(posedge mclk_in);
        cor_evt <= c;
        unc_evt <= u;
        if (m != 4'h0) mq.push_back(m);
        exp_msgs += m.cor + m.nonfatal + m.fatal;
        @(posedge mclk_in);
        cor_evt <= '0;
        unc_evt <= 32'h0;
        repeat (2) @(posedge mclk_in);
    endtask : ev

    // ------------------------------------------------------------
    // Output watchers taking the oldest note
    // ------------------------------------------------------------
    always @(posedge mclk_in) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            chk(bvalid ? {32'h0, bresp} : {rdata, rresp}, rq.pop_front());
        end
        if (!por_rst_in && msg !== 4'h0) begin
            chk(34'(msg), (mq.size() > 0) ? 34'(mq.pop_front()) : 34'h0);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_in, por_rst_in, ds_port, awvalid, wvalid, bready, arvalid, rready} = 8'hC0;
        {cor_evt, unc_evt, wdata, awaddr, araddr} = '0;
        i = $urandom(32'hA67B8C03);
        repeat (16) @(posedge mclk_in);
        por_rst_in <= 1'b0;
        rst_in <= 1'b0;
        axr(PAS_OFS_UNC_SEV, PAS_SEV_RST, PAS_RESP_OKAY);
        axr(PAS_OFS_COR_STAT, 32'h0, PAS_RESP_OKAY);
        axr(PAS_OFS_COR_MASK, 32'h0000_2000, PAS_RESP_OKAY);
        axr(PAS_OFS_IRQ_MASK, PAS_IRQ_MASK_RST, PAS_RESP_OKAY);
        axr(12'h000, 32'h0, PAS_RESP_SLVERR);
        axw(12'h000, $urandom, PAS_RESP_SLVERR);
        axw(PAS_OFS_COR_MASK, 32'hFFFF_FFFF, PAS_RESP_OKAY);
        axr(PAS_OFS_COR_MASK, 32'h0000_31C1, PAS_RESP_OKAY);
        axw(PAS_OFS_UNC_SEV, 32'hFFFF_FFFF, PAS_RESP_OKAY);
        axr(PAS_OFS_UNC_SEV, 32'h003F_F031, PAS_RESP_OKAY);
        wstrb <= 4'h2;
        axw(PAS_OFS_UNC_SEV, 32'h0, PAS_RESP_OKAY);
        wstrb <= 4'hF;
        axr(PAS_OFS_UNC_SEV, 32'h003F_0031, PAS_RESP_OKAY);
        axw(PAS_OFS_COR_MASK, 32'h0, PAS_RESP_OKAY);
        axw(PAS_OFS_UNC_SEV, 32'h0000_0010, PAS_RESP_OKAY);
        for (i = 0; i < 6; i++) begin
            ev(6'(1 << i), 32'h0, 4'hC);
            axw(PAS_OFS_COR_STAT, $urandom & ~(32'h1 << bits[i]), PAS_RESP_OKAY);
            axr(PAS_OFS_COR_STAT, 32'h1 << bits[i], PAS_RESP_OKAY);
            axw(PAS_OFS_COR_STAT, 32'h1 << bits[i], PAS_RESP_OKAY);
            axr(PAS_OFS_COR_STAT, 32'h0, PAS_RESP_OKAY);
        end
        axw(PAS_OFS_COR_MASK, 32'h0000_31C1, PAS_RESP_OKAY);
        axw(PAS_OFS_IRQ_MASK, 32'h0, PAS_RESP_OKAY);
        for (i = 0; i < 6; i++) ev(6'(1 << i), 32'h0, 4'h0);
        ev('0, 32'h0000_0010, 4'h1);
        axr(PAS_OFS_COR_STAT, 32'h0000_31C1, PAS_RESP_OKAY);
        chk({33'h0, irq}, 34'h1);
        rst_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        axr(PAS_OFS_COR_STAT, 32'h0000_31C1, PAS_RESP_OKAY);
        axr(PAS_OFS_COR_MASK, 32'h0000_31C1, PAS_RESP_OKAY);
        chk({33'h0, irq}, 34'h1);
        axw(PAS_OFS_COR_STAT, 32'h0000_31C1, PAS_RESP_OKAY);
        axr(PAS_OFS_COR_STAT, 32'h0, PAS_RESP_OKAY);
        chk({33'h0, irq}, 34'h0);
        ev('0, 32'h0000_1000, 4'h2);
        ev('0, 32'h0000_1010, 4'h3);
        ev('0, 32'h0000_0020, 4'h0);
        ds_port <= 1'b1;
        ev('0, 32'h0000_0020, 4'h2);
        axw(PAS_OFS_UNC_SEV, 32'h0000_0030, PAS_RESP_OKAY);
        ev('0, 32'h0000_0020, 4'h1);
        repeat (4) @(posedge mclk_in);
        chk(34'(rq.size() + mq.size()), 34'h0);
        chk(34'(rc_total), 34'(exp_msgs));
        tally_and_finish();
    end
endmodule : tb

bind pas_regs pas_regs_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .por_rst_in(por_rst_in),
    .downstream_port_in(downstream_port_in), .cor_evt_in(cor_evt_in), .unc_evt_in(unc_evt_in),
    .s_axil_araddr_in(s_axil_araddr_in), .s_axil_arvalid_in(s_axil_arvalid_in),
    .s_axil_arready_out(s_axil_arready_out), .s_axil_rdata_out(s_axil_rdata_out),
    .s_axil_rresp_out(s_axil_rresp_out), .s_axil_rvalid_out(s_axil_rvalid_out),
    .s_axil_bvalid_out(s_axil_bvalid_out), .msg_out(msg_out), .irq_out(irq_out));
